// *** hdl/cpx_pkg.sv ***
package cpx_pkg;

	// ----------------------------------------
	// register offsets on the io bus
	// ----------------------------------------
	localparam logic [3:0] CPX_OFF_GUARD = 4'h4;
	localparam logic [3:0] CPX_OFF_DIRECT = 4'h8;
	localparam logic [3:0] CPX_OFF_FIRST = 4'h9;
	localparam logic [3:0] CPX_OFF_SECOND = 4'ha;
	localparam logic [3:0] CPX_OFF_THIRD = 4'hb;
	localparam logic [3:0] CPX_OFF_FAR = 4'hc;
	localparam logic [3:0] CPX_OFF_SPL = 4'hd;
	localparam logic [3:0] CPX_OFF_SPH = 4'he;
	localparam logic [3:0] CPX_OFF_FLAGS = 4'hf;

	// ----------------------------------------
	// flag bit positions
	// ----------------------------------------
	localparam int CPX_BIT_C = 0;
	localparam int CPX_BIT_Z = 1;
	localparam int CPX_BIT_N = 2;
	localparam int CPX_BIT_V = 3;
	localparam int CPX_BIT_S = 4;
	localparam int CPX_BIT_H = 5;
	localparam int CPX_BIT_T = 6;
	localparam int CPX_BIT_I = 7;

	// ----------------------------------------
	// reset values and sizes
	// ----------------------------------------
	localparam logic [7:0] CPX_EXT_RST = 8'h00;
	localparam logic [7:0] CPX_FLAGS_RST = 8'h00;
	localparam logic [7:0] CPX_TEMP_RST = 8'h00;
	localparam int CPX_PTR_W = 16;
	localparam int CPX_EXT_W = 8;
	localparam int CPX_EXT_N = 5;
	// byte address bits covering the first 128k bytes of program memory
	localparam int CPX_PWORD_BITS = 17;

	// index of each extension register in the bank
	typedef enum logic [2:0] {
		CPX_EXT_DIRECT = 3'h0,
		CPX_EXT_FIRST = 3'h1,
		CPX_EXT_SECOND = 3'h2,
		CPX_EXT_THIRD = 3'h3,
		CPX_EXT_FAR = 3'h4
	} cpx_ext_t;

	// mask of implemented bits for a register holding 'bits' address bits
	function automatic logic [7:0] cpx_ext_mask(input int bits);
		logic [7:0] m;
		m = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (i < bits)
				m[i] = 1'b1;
		end
		return m;
	endfunction

	function automatic logic cpx_hit(input logic [3:0] addr,
		input logic [3:0] off);
		return addr == off;
	endfunction

endpackage

// *** hdl/cpx_ext_reg.sv ***
module cpx_ext_reg
	import cpx_pkg::*;
#(
	parameter logic [7:0] MASK = 8'hff
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] q_o
);

	logic [7:0] val_ff;
	logic [7:0] nxt_val;

	always_comb begin
		nxt_val = val_ff;
		if (wr_i)
			nxt_val = wdata_i & MASK; // [RULE10]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			val_ff <= CPX_EXT_RST & MASK;
		else
			val_ff <= nxt_val;
	end

	assign q_o = val_ff;

	unimpl_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
		(q_o & ~MASK) == 8'h00)
		else $error("unimplemented extension bit is set");

	ext_write_a: assert property ( // [RULE10]
		@(posedge clk_i) disable iff (rst_i)
		wr_i |=> q_o == ($past(wdata_i) & MASK))
		else $error("extension write not stored");

endmodule

// *** hdl/cpx_flags.sv ***
module cpx_flags
	import cpx_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	input wire logic alu_we_i,
	input wire logic alu_c_i,
	input wire logic alu_z_i,
	input wire logic alu_n_i,
	input wire logic alu_v_i,
	input wire logic alu_h_i,
	input wire logic tcap_i,
	input wire logic tbit_i,
	input wire logic irq_on_i,
	input wire logic irq_off_i,
	output logic [7:0] flags_o
);

	logic [7:0] fl_ff;
	logic [7:0] nxt_fl;

	always_comb begin
		nxt_fl = fl_ff;
		if (wr_i) begin
			nxt_fl = wdata_i;
		end else begin
			if (alu_we_i) begin // [RULE21]
				nxt_fl[CPX_BIT_C] = alu_c_i; // [RULE19]
				nxt_fl[CPX_BIT_H] = alu_h_i; // [RULE19]
				nxt_fl[CPX_BIT_V] = alu_v_i; // [RULE19]
				nxt_fl[CPX_BIT_N] = alu_n_i; // [RULE18]
				nxt_fl[CPX_BIT_Z] = alu_z_i; // [RULE18]
			end
			if (tcap_i)
				nxt_fl[CPX_BIT_T] = tbit_i; // [RULE16]
			// no interrupt-taken input: acceptance never touches the enable
			if (irq_on_i)
				nxt_fl[CPX_BIT_I] = 1'b1; // [RULE15]
			else if (irq_off_i)
				nxt_fl[CPX_BIT_I] = 1'b0; // [RULE15]
		end
		// sign is never stored on its own, so it cannot drift
		nxt_fl[CPX_BIT_S] = nxt_fl[CPX_BIT_N] ^ nxt_fl[CPX_BIT_V]; // [RULE17]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			fl_ff <= CPX_FLAGS_RST;
		else
			fl_ff <= nxt_fl;
	end

	assign flags_o = fl_ff;

	sign_xor_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE17]
		flags_o[CPX_BIT_S] == (flags_o[CPX_BIT_N] ^ flags_o[CPX_BIT_V]))
		else $error("sign flag differs from n xor v");

	gie_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE15]
		!wr_i && !irq_off_i && flags_o[CPX_BIT_I] |=> flags_o[CPX_BIT_I])
		else $error("interrupt enable cleared without cause");

	tcap_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE16]
		tcap_i && !wr_i |=> flags_o[CPX_BIT_T] == $past(tbit_i))
		else $error("bit store did not reach t flag");

	alu_keep_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE21]
		!alu_we_i && !wr_i |=> $stable(flags_o[2:0]))
		else $error("result flags changed with no update");

	alu_take_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE18]
		alu_we_i && !wr_i |=> flags_o[CPX_BIT_Z] == $past(alu_z_i)
		&& flags_o[CPX_BIT_N] == $past(alu_n_i)
		&& flags_o[CPX_BIT_C] == $past(alu_c_i))
		else $error("result flags not taken from alu");

endmodule

// *** hdl/cpx_regs.sv ***
// What this block does
// RULE1: first pointer pair address is first_ptr_ext above the 16-bit pair.
// RULE2: second pointer pair address is second_ptr_ext above the 16-bit pair.
// RULE3: third pointer pair data address is third_ptr_ext above the pair.
// RULE4: extended program reads take third_ptr_ext as upper byte.
// RULE5: flash writes take third_ptr_ext as upper byte.
// RULE6: third_ptr_ext has no effect on low data and program addresses.
// RULE7: first and second extensions unused below 64k, absent on small parts.
// RULE8: far jump and call target is far_jump_ext above third pointer pair.
// RULE9: far_jump_ext ignored below 128k, absent on small program memory.
// RULE10: extension registers keep only needed bits; others read zero.
// RULE11: stack pointer is 16 bits split over low and high registers.
// RULE12: reset loads stack pointer with highest internal sram address.
// RULE13: stack pointer keeps only needed bits up to 64k; rest read zero.
// RULE14: with global enable clear no interrupt is enabled.
// RULE15: enable changes only by set, clear instructions or writes.
// RULE16: t flag receives bit on capture, and feeds bit deposit.
// RULE17: sign flag always equals negative xor overflow.
// RULE18: bit 2 marks negative result, bit 1 marks zero result.
// RULE19: bit 0 carry, bit 5 half carry, bit 3 overflow.
// RULE20: stack bytes pair through a temp: low written and read first.
// RULE21: flags hold until next flag-affecting instruction or direct write.
module cpx_regs
	import cpx_pkg::*;
#(
	parameter int DATA_AW = 24,
	parameter int PROG_AW = 24,
	parameter logic [15:0] SRAM_TOP = 16'h3fff
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// io bus
	input wire logic [3:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	// pointer pairs and direct operand from the core
	input wire logic [15:0] ptr_first_i,
	input wire logic [15:0] ptr_second_i,
	input wire logic [15:0] ptr_third_i,
	input wire logic [15:0] direct_op_i,
	output logic [23:0] addr_first_o,
	output logic [23:0] addr_second_o,
	output logic [23:0] addr_third_o,
	output logic [23:0] addr_direct_o,
	output logic [23:0] prog_read_addr_o,
	output logic [23:0] flash_write_addr_o,
	output logic [23:0] far_target_o,
	// stack pointer from the core
	input wire logic sp_we_i,
	input wire logic [15:0] sp_d_i,
	output logic [15:0] stack_ptr_o,
	// flag updates from execution
	input wire logic alu_we_i,
	input wire logic alu_c_i,
	input wire logic alu_z_i,
	input wire logic alu_n_i,
	input wire logic alu_v_i,
	input wire logic alu_h_i,
	input wire logic flag_capture_op_i,
	input wire logic capture_bit_i,
	output logic t_flag_o,
	input wire logic irq_on_op_i,
	input wire logic irq_off_op_i,
	output logic [7:0] flags_o,
	// interrupt gating
	input wire logic irq_pending_i,
	output logic irq_req_o
);

	// ----------------------------------------
	// sizes of implemented fields
	// ----------------------------------------
	localparam int DEXT_BITS = (DATA_AW > CPX_PTR_W) ? DATA_AW - CPX_PTR_W : 0;
	localparam int PEXT_BITS = (PROG_AW > CPX_PTR_W) ? PROG_AW - CPX_PTR_W : 0;
	localparam int ZEXT_BITS = (DEXT_BITS > PEXT_BITS) ? DEXT_BITS : PEXT_BITS;
	localparam int FEXT_BITS = (PROG_AW > CPX_PWORD_BITS) ?
		PROG_AW - CPX_PWORD_BITS : 0;
	localparam int SP_BITS = (DATA_AW < CPX_PTR_W) ? DATA_AW : CPX_PTR_W;
	localparam logic [15:0] SP_MASK = 16'((32'h1 << SP_BITS) - 32'h1);
	localparam logic [15:0] SP_RST = SRAM_TOP & SP_MASK;

	// absent registers get an all-zero mask and so read as zero
	localparam logic [7:0] EXT_MASK [CPX_EXT_N] = '{
		cpx_ext_mask(DEXT_BITS), // [RULE7]
		cpx_ext_mask(DEXT_BITS), // [RULE7]
		cpx_ext_mask(DEXT_BITS), // [RULE7]
		cpx_ext_mask(ZEXT_BITS),
		cpx_ext_mask(FEXT_BITS) // [RULE9]
	};
	localparam logic [3:0] EXT_OFF [CPX_EXT_N] = '{
		CPX_OFF_DIRECT,
		CPX_OFF_FIRST,
		CPX_OFF_SECOND,
		CPX_OFF_THIRD,
		CPX_OFF_FAR
	};

	// ----------------------------------------
	// extension register bank
	// ----------------------------------------
	logic [7:0] ext_q [CPX_EXT_N];

	for (genvar g = 0; g < CPX_EXT_N; g++) begin : g_ext
		cpx_ext_reg #(
			.MASK(EXT_MASK[g])
		) u_ext (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.wr_i(io_wr_i && cpx_hit(io_addr_i, EXT_OFF[g])),
			.wdata_i(io_wdata_i),
			.q_o(ext_q[g])
		);
	end

	// ----------------------------------------
	// address forming
	// ----------------------------------------
	// a zero upper byte leaves the 16-bit address unchanged
	assign addr_first_o = {ext_q[CPX_EXT_FIRST], ptr_first_i}; // [RULE1] [RULE7]
	assign addr_second_o = {ext_q[CPX_EXT_SECOND], ptr_second_i}; // [RULE2]
	assign addr_third_o = {ext_q[CPX_EXT_THIRD], ptr_third_i}; // [RULE3] [RULE6]
	assign addr_direct_o = {ext_q[CPX_EXT_DIRECT], direct_op_i};
	assign prog_read_addr_o = {ext_q[CPX_EXT_THIRD], ptr_third_i}; // [RULE4]
	assign flash_write_addr_o = {ext_q[CPX_EXT_THIRD], ptr_third_i}; // [RULE5]
	// word target: the extension supplies bits above the 16-bit pointer
	assign far_target_o = {ext_q[CPX_EXT_FAR], ptr_third_i}; // [RULE8] [RULE9]

	// ----------------------------------------
	// stack pointer and shared temp
	// ----------------------------------------
	logic [15:0] sp_ff;
	logic [15:0] nxt_sp;
	logic [7:0] temp_ff;
	logic [7:0] nxt_temp;
	logic wr_spl;
	logic wr_sph;
	logic rd_spl;

	assign wr_spl = io_wr_i && cpx_hit(io_addr_i, CPX_OFF_SPL);
	assign wr_sph = io_wr_i && cpx_hit(io_addr_i, CPX_OFF_SPH);
	assign rd_spl = io_rd_i && cpx_hit(io_addr_i, CPX_OFF_SPL);

	always_comb begin
		nxt_sp = sp_ff;
		nxt_temp = temp_ff;
		if (wr_spl)
			nxt_temp = io_wdata_i; // [RULE20]
		else if (rd_spl)
			nxt_temp = sp_ff[15:8]; // [RULE20]
		// high byte write moves both halves at once
		if (wr_sph)
			nxt_sp = {io_wdata_i, temp_ff} & SP_MASK; // [RULE20] [RULE13]
		else if (sp_we_i)
			nxt_sp = sp_d_i & SP_MASK; // [RULE11] [RULE13]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sp_ff <= SP_RST; // [RULE12]
			temp_ff <= CPX_TEMP_RST;
		end else begin
			sp_ff <= nxt_sp;
			temp_ff <= nxt_temp;
		end
	end

	assign stack_ptr_o = sp_ff;

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	logic wr_flags;

	assign wr_flags = io_wr_i && cpx_hit(io_addr_i, CPX_OFF_FLAGS);

	cpx_flags u_flags (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_i(wr_flags),
		.wdata_i(io_wdata_i),
		.alu_we_i(alu_we_i),
		.alu_c_i(alu_c_i),
		.alu_z_i(alu_z_i),
		.alu_n_i(alu_n_i),
		.alu_v_i(alu_v_i),
		.alu_h_i(alu_h_i),
		.tcap_i(flag_capture_op_i),
		.tbit_i(capture_bit_i),
		.irq_on_i(irq_on_op_i),
		.irq_off_i(irq_off_op_i),
		.flags_o(flags_o)
	);

	assign t_flag_o = flags_o[CPX_BIT_T]; // [RULE16]
	assign irq_req_o = irq_pending_i && flags_o[CPX_BIT_I]; // [RULE14]

	// ----------------------------------------
	// read data
	// ----------------------------------------
	// registered one cycle after the read strobe; guard reads as zero here
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;

	always_comb begin
		nxt_rdata = rdata_ff;
		if (io_rd_i) begin
			nxt_rdata = 8'h00;
			for (int i = 0; i < CPX_EXT_N; i++) begin
				if (cpx_hit(io_addr_i, EXT_OFF[i]))
					nxt_rdata = ext_q[i]; // [RULE10]
			end
			case (io_addr_i)
				CPX_OFF_SPL: nxt_rdata = sp_ff[7:0];
				CPX_OFF_SPH: nxt_rdata = temp_ff; // [RULE20]
				CPX_OFF_FLAGS: nxt_rdata = flags_o;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= nxt_rdata;
	end

	assign io_rdata_o = rdata_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sp_reset_a: assert property (@(posedge clk_i) // [RULE12]
		rst_i |=> stack_ptr_o == SP_RST)
		else $error("stack pointer reset value wrong");

	sp_pair_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE20]
		wr_spl ##1 wr_sph |=>
		stack_ptr_o == ({$past(io_wdata_i), $past(io_wdata_i, 2)} & SP_MASK))
		else $error("stack pointer pair write wrong");

	sp_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE20]
		rd_spl && !wr_spl && !wr_sph && !sp_we_i ##1
		io_rd_i && cpx_hit(io_addr_i, CPX_OFF_SPH) |=>
		io_rdata_o == $past(stack_ptr_o[15:8], 2))
		else $error("stack high byte not paired with low read");

	sp_bits_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE13]
		(stack_ptr_o & ~SP_MASK) == 16'h0000)
		else $error("unimplemented stack bit set");

	first_addr_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE1]
		io_wr_i && cpx_hit(io_addr_i, CPX_OFF_FIRST) |=>
		addr_first_o[23:16] == ($past(io_wdata_i) & EXT_MASK[CPX_EXT_FIRST])
		&& addr_first_o[15:0] == ptr_first_i)
		else $error("first pointer address wrong");

	far_target_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
		io_wr_i && cpx_hit(io_addr_i, CPX_OFF_FAR) |=>
		far_target_o == {$past(io_wdata_i) & EXT_MASK[CPX_EXT_FAR],
		ptr_third_i})
		else $error("far jump target wrong");

	irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE14]
		!flags_o[CPX_BIT_I] |-> !irq_req_o)
		else $error("interrupt requested while disabled");

	irq_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE14]
		irq_off_op_i && !irq_on_op_i && !wr_flags |=> !irq_req_o)
		else $error("interrupt request after disable");

	second_addr_a: assert property ( // [RULE2]
		@(posedge clk_i) disable iff (rst_i)
		io_wr_i && cpx_hit(io_addr_i, CPX_OFF_SECOND) |=>
		addr_second_o == {$past(io_wdata_i) & EXT_MASK[CPX_EXT_SECOND],
		ptr_second_i})
		else $error("second pointer address wrong");

	third_addr_a: assert property ( // [RULE3]
		@(posedge clk_i) disable iff (rst_i)
		io_wr_i && cpx_hit(io_addr_i, CPX_OFF_THIRD) |=>
		addr_third_o == {$past(io_wdata_i) & EXT_MASK[CPX_EXT_THIRD],
		ptr_third_i})
		else $error("third pointer address wrong");

	third_prog_a: assert property ( // [RULE4] [RULE5]
		@(posedge clk_i) disable iff (rst_i)
		io_wr_i && cpx_hit(io_addr_i, CPX_OFF_THIRD) |=>
		prog_read_addr_o == {$past(io_wdata_i) & EXT_MASK[CPX_EXT_THIRD],
		ptr_third_i}
		&& flash_write_addr_o[23:16] ==
		($past(io_wdata_i) & EXT_MASK[CPX_EXT_THIRD]))
		else $error("program address upper byte wrong");

	sp_load_a: assert property ( // [RULE11] [RULE13]
		@(posedge clk_i) disable iff (rst_i)
		sp_we_i && !wr_sph |=>
		stack_ptr_o == ($past(sp_d_i) & SP_MASK))
		else $error("core stack pointer load wrong");

	ext_read_a: assert property ( // [RULE10]
		@(posedge clk_i) disable iff (rst_i)
		io_rd_i && cpx_hit(io_addr_i, CPX_OFF_THIRD) |=>
		(io_rdata_o & ~EXT_MASK[CPX_EXT_THIRD]) == 8'h00)
		else $error("unimplemented bit read as one");

	flags_read_a: assert property ( // [RULE21]
		@(posedge clk_i) disable iff (rst_i)
		io_rd_i && cpx_hit(io_addr_i, CPX_OFF_FLAGS) |=>
		io_rdata_o == $past(flags_o))
		else $error("status read does not match flags");

	irq_set_a: assert property ( // [RULE15]
		@(posedge clk_i) disable iff (rst_i)
		irq_on_op_i && !wr_flags |=> flags_o[CPX_BIT_I])
		else $error("interrupt enable not set");

endmodule

// *** verif/cpx_core_model.sv ***
// ----------------------------------------
// core side io bus master
// ----------------------------------------
module cpx_core_model
	import cpx_pkg::*;
(
	input wire logic clk_i,
	output logic [3:0] io_addr_o,
	output logic io_wr_o,
	output logic io_rd_o,
	output logic [7:0] io_wdata_o,
	input wire logic [7:0] io_rdata_i
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		io_addr_o = 4'h0;
		io_wr_o = 1'b0;
		io_rd_o = 1'b0;
		io_wdata_o = 8'h00;
	end

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		io_addr_o <= a;
		io_wdata_o <= d;
		io_wr_o <= 1'b1;
		@(posedge clk_i);
		io_wr_o <= 1'b0;
		// released bus must not keep showing the old byte
		io_wdata_o <= ~d;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_i);
		io_addr_o <= a;
		io_rd_o <= 1'b1;
		@(posedge clk_i);
		io_rd_o <= 1'b0;
		#1;
		d = io_rdata_i;
	endtask

	// both halves in consecutive cycles, strobe held high between them
	task automatic sp_write(input logic [15:0] v);
		@(posedge clk_i);
		io_addr_o <= CPX_OFF_SPL;
		io_wdata_o <= v[7:0];
		io_wr_o <= 1'b1;
		@(posedge clk_i);
		io_addr_o <= CPX_OFF_SPH;
		io_wdata_o <= v[15:8];
		@(posedge clk_i);
		io_wr_o <= 1'b0;
		io_wdata_o <= ~v[15:8];
	endtask

	task automatic sp_read(output logic [15:0] v);
		@(posedge clk_i);
		io_addr_o <= CPX_OFF_SPL;
		io_rd_o <= 1'b1;
		@(posedge clk_i);
		io_addr_o <= CPX_OFF_SPH;
		#1;
		v[7:0] = io_rdata_i;
		@(posedge clk_i);
		io_rd_o <= 1'b0;
		#1;
		v[15:8] = io_rdata_i;
	endtask
endmodule

// *** verif/cpu_pointer_ext_and_flags_bench.sv ***
module cpu_pointer_ext_and_flags_bench
	import cpx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk_i, rst_i;
	logic [3:0] io_addr;
	logic io_wr, io_rd, sp_we, alu_we, c, z, n, v, h, cap, cbit;
	logic on, off, pend, req, t_flag;
	logic [7:0] io_wdata, io_rdata, flags, d8;
	logic [15:0] p1, p2, p3, dop, sp_d, sp_q, d16;
	logic [23:0] a1, a2, a3, ad, pr, fw, ft;
	int n_fail = 0;
	int checked = 0;
	// parts sized so that the data, third and far extensions keep different bit counts
	logic [3:0] offs [5] = '{CPX_OFF_DIRECT, CPX_OFF_FIRST,
		CPX_OFF_SECOND, CPX_OFF_THIRD, CPX_OFF_FAR};
	logic [7:0] msk [5] = '{8'h0f, 8'h0f, 8'h0f, 8'h3f, 8'h1f};

	cpx_regs #(.DATA_AW(20), .PROG_AW(22), .SRAM_TOP(16'h2fff))
		cpx_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .io_addr_i(io_addr),
		.io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata),
		.io_rdata_o(io_rdata), .ptr_first_i(p1), .ptr_second_i(p2),
		.ptr_third_i(p3), .direct_op_i(dop), .addr_first_o(a1),
		.addr_second_o(a2), .addr_third_o(a3), .addr_direct_o(ad),
		.prog_read_addr_o(pr), .flash_write_addr_o(fw), .far_target_o(ft),
		.sp_we_i(sp_we), .sp_d_i(sp_d), .stack_ptr_o(sp_q),
		.alu_we_i(alu_we), .alu_c_i(c), .alu_z_i(z), .alu_n_i(n),
		.alu_v_i(v), .alu_h_i(h), .flag_capture_op_i(cap),
		.capture_bit_i(cbit), .t_flag_o(t_flag), .irq_on_op_i(on),
		.irq_off_op_i(off), .flags_o(flags), .irq_pending_i(pend),
		.irq_req_o(req));

	cpx_core_model cpx_core_model_inst (.clk_i(clk_i), .io_addr_o(io_addr),
		.io_wr_o(io_wr), .io_rd_o(io_rd), .io_wdata_o(io_wdata),
		.io_rdata_i(io_rdata));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic alu(input logic [4:0] hvnzc);
		@(posedge clk_i);
		{h, v, n, z, c} <= hvnzc;
		alu_we <= 1'b1;
		@(posedge clk_i);
		alu_we <= 1'b0;
		#1;
	endtask

	task automatic op(input logic [2:0] cap_on_off);
		@(posedge clk_i);
		{cap, on, off} <= cap_on_off;
		@(posedge clk_i);
		{cap, on, off} <= 3'h0;
		#1;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [7:0] e;
		chk(sp_q, 16'h2fff);
		for (int o = 0; o < 16; o++) begin
			e = (o == CPX_OFF_SPL) ? 8'hff : (o == CPX_OFF_SPH) ? 8'h2f : 8'h00;
			cpx_core_model_inst.rd(o[3:0], d8);
			chk(d8, e);
		end
	endtask

	task automatic t_ext();
		@(posedge clk_i);
		p1 <= 16'h1234;
		p2 <= 16'h5678;
		p3 <= 16'h9abc;
		dop <= 16'hdef0;
		for (int i = 0; i < 5; i++) begin
			cpx_core_model_inst.wr(offs[i], 8'hff);
			cpx_core_model_inst.rd(offs[i], d8);
			chk(d8, msk[i]);
		end
		cpx_core_model_inst.wr(4'h5, 8'h5a);
		cpx_core_model_inst.rd(4'h5, d8);
		chk(d8, 8'h00);
		chk(a1, 24'h0f1234);
		chk(a2, 24'h0f5678);
		chk(a3, 24'h3f9abc);
		chk(ad, 24'h0fdef0);
		chk(pr, 24'h3f9abc);
		chk(fw, 24'h3f9abc);
		chk(ft, 24'h1f9abc);
		cpx_core_model_inst.wr(CPX_OFF_THIRD, 8'h00);
		cpx_core_model_inst.wr(CPX_OFF_FIRST, 8'h00);
		cpx_core_model_inst.wr(CPX_OFF_FAR, 8'h00);
		#1;
		chk(pr, 24'h009abc);
		chk(a1, 24'h001234);
		chk(ft, 24'h009abc);
	endtask

	task automatic t_stack();
		cpx_core_model_inst.sp_write(16'h1234);
		#1;
		chk(sp_q, 16'h1234);
		cpx_core_model_inst.sp_read(d16);
		chk(d16, 16'h1234);
		// core reload between the two byte reads must not tear the pair
		cpx_core_model_inst.rd(CPX_OFF_SPL, d8);
		@(posedge clk_i);
		sp_d <= 16'habcd;
		sp_we <= 1'b1;
		@(posedge clk_i);
		sp_we <= 1'b0;
		cpx_core_model_inst.rd(CPX_OFF_SPH, d8);
		chk(d8, 8'h12);
		chk(sp_q, 16'habcd);
	endtask

	task automatic t_flags();
		alu(5'b10101);
		chk(flags, 8'h35);
		repeat (5) @(posedge clk_i);
		chk(flags, 8'h35);
		alu(5'b01110);
		chk(flags, 8'h0e);
		op(3'b100);
		chk(t_flag, 1'b1);
		chk(flags, 8'h4e);
		@(posedge clk_i);
		pend <= 1'b1;
		#1;
		chk(req, 1'b0);
		op(3'b010);
		chk(req, 1'b1);
		alu(5'b00000);
		chk(flags, 8'hc0);
		cpx_core_model_inst.wr(CPX_OFF_FLAGS, 8'hff);
		#1;
		chk(flags, 8'hef);
		op(3'b001);
		chk(flags, 8'h6f);
		chk(req, 1'b0);
		cpx_core_model_inst.rd(CPX_OFF_FLAGS, d8);
		chk(d8, 8'h6f);
	endtask

	// second reset in mid-run, with state left from the scenarios above
	task automatic t_rerun();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		chk(sp_q, 16'h2fff);
		chk(flags, 8'h00);
		chk(req, 1'b0);
		chk(a2, 24'h005678);
		chk(ad, 24'h00def0);
		chk(io_rdata, 8'h00);
		cpx_core_model_inst.sp_read(d16);
		chk(d16, 16'h2fff);
	endtask

	initial begin
		repeat (5000) @(posedge clk_i);
		n_fail++;
		print_verdict();
	end

	initial begin
		rst_i = 1'b1;
		{sp_we, alu_we, c, z, n, v, h, cap, on, off, pend} = 11'h000;
		cbit = 1'b1;
		{p1, p2, p3, dop, sp_d} = 80'h0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_ext();
		t_stack();
		t_flags();
		t_rerun();
		print_verdict();
	end
endmodule
